// ==== common/pwg_pkg.sv ====
// Shared constants for the multi-generator PWM block
package pwg_pkg;
	// Structure
	localparam int PWG_NGEN = 2; // Number of generators
	localparam int PWG_AW = 8; // Byte address width
	localparam int PWG_DW = 32; // Bus data width
	localparam int PWG_CW = 16; // Counter and compare width
	localparam int PWG_NISC = 3; // Status bits per generator
	localparam int PWG_DIVW = 3; // Divider field width
	localparam int PWG_PSW = 7; // Prescaler width, holds 2**7-1
	// Global register byte offsets
	localparam logic [7:0] PWG_OFS_CLKCFG = 8'h00;
	localparam logic [7:0] PWG_OFS_SYNC = 8'h04;
	localparam logic [7:0] PWG_OFS_IRQSTAT = 8'h08;
	localparam logic [7:0] PWG_OFS_IRQMASK = 8'h0C;
	// Generator windows
	localparam logic [7:0] PWG_GEN_BASE = 8'h40;
	localparam logic [7:0] PWG_GEN_STRIDE = 8'h20;
	localparam logic [7:0] PWG_GOFS_CTL = 8'h00;
	localparam logic [7:0] PWG_GOFS_LOAD = 8'h04;
	localparam logic [7:0] PWG_GOFS_CMPA = 8'h08;
	localparam logic [7:0] PWG_GOFS_CMPB = 8'h0C;
	localparam logic [7:0] PWG_GOFS_COUNT = 8'h10;
	localparam logic [7:0] PWG_GOFS_ISC = 8'h14;
	// Generator control field positions
	localparam int PWG_CTL_EN = 0;
	localparam int PWG_CTL_LDIE = 1;
	localparam int PWG_CTL_CAIE = 2;
	localparam int PWG_CTL_CBIE = 3;
	localparam int PWG_CTLW = 4;
	// Generator status field positions
	localparam int PWG_ISC_LD = 0;
	localparam int PWG_ISC_CA = 1;
	localparam int PWG_ISC_CB = 2;
	// Divider field position
	localparam int PWG_DIV_LSB = 0;
	// Reset values
	localparam logic [PWG_DIVW-1:0] PWG_RST_DIV = 3'h0;
	localparam logic [PWG_CW-1:0] PWG_RST_CNT = 16'h0000;
	localparam logic [PWG_DW-1:0] PWG_RST_WORD = 32'h00000000;
endpackage : pwg_pkg

// ==== logic/pwg_gen.sv ====
// One PWM generator: down counter, events, and tick-timed status clear
`timescale 1ns/1ns
module pwg_gen import pwg_pkg::*; (
	input wire logic i_mclk,
	input wire logic i_reset,
	input wire logic i_ce,
	input wire logic i_tick,
	input wire logic i_div_zero,
	input wire logic i_sync,
	input wire logic [PWG_CTLW-1:0] i_ctl,
	input wire logic [PWG_CW-1:0] i_load,
	input wire logic [PWG_CW-1:0] i_cmpa,
	input wire logic [PWG_CW-1:0] i_cmpb,
	input wire logic i_isc_wr,
	input wire logic [PWG_NISC-1:0] i_isc_data,
	output logic [PWG_CW-1:0] o_count,
	output logic [PWG_NISC-1:0] o_isc,
	output logic o_irq
);
	logic en_q; // Enable seen last cycle
	logic [PWG_NISC-1:0] fresh; // Bits set since the last counter tick
	logic [PWG_NISC-1:0] pend; // Accepted clears waiting for a tick
	wire en = i_ctl[PWG_CTL_EN];
	wire [PWG_NISC-1:0] ie = {i_ctl[PWG_CTL_CBIE], i_ctl[PWG_CTL_CAIE], i_ctl[PWG_CTL_LDIE]};
	wire step = en & i_tick; // Counter advances only on the divided clock
	// Sync is only certain to land when the divider is bypassed
	wire sync_ok = i_sync & (i_div_zero | i_tick);
	// Spurious load event as the generator is switched on
	wire en_rise = en & ~en_q;
	wire cmp_below = (i_cmpa < i_load) | (i_cmpb < i_load);
	wire spur = en_rise & (i_load != PWG_RST_CNT) & cmp_below;
	// Counter events sampled on a tick, plus the spurious load event on enable
	wire ev_ld = (step & (o_count == PWG_RST_CNT)) | spur;
	wire ev_ca = step & (o_count == i_cmpa);
	wire ev_cb = step & (o_count == i_cmpb);
	wire [PWG_NISC-1:0] ev = {ev_cb, ev_ca, ev_ld} & ie;
	// A clear is refused for bits that have not yet seen a tick
	wire [PWG_NISC-1:0] wr_acc = i_isc_wr ? (i_isc_data & o_isc & ~fresh) : 3'h0;
	wire [PWG_NISC-1:0] clr_now = i_tick ? pend : 3'h0;
	wire [PWG_NISC-1:0] next_isc = (o_isc & ~clr_now) | ev; // Set wins over clear
	wire [PWG_NISC-1:0] next_fresh = (i_tick ? 3'h0 : fresh) | ev;
	wire [PWG_NISC-1:0] next_pend = ((i_tick ? 3'h0 : pend) | wr_acc) & ~ev;
	// Counter next value: sync reload first, then count down and wrap
	wire [PWG_CW-1:0] next_count = sync_ok ? i_load :
		!step ? o_count :
		(o_count == PWG_RST_CNT) ? i_load : o_count - 16'h0001;

	// Counter and enable history
	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			o_count <= PWG_RST_CNT;
			en_q <= 1'b0;
		end else if (i_ce) begin
			o_count <= next_count;
			en_q <= en;
		end
	end

	// Status, freshness and pending clears
	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			o_isc <= 3'h0;
			fresh <= 3'h0;
			pend <= 3'h0;
			o_irq <= 1'b0;
		end else if (i_ce) begin
			o_isc <= next_isc;
			fresh <= next_fresh;
			pend <= next_pend;
			o_irq <= |next_isc;
		end
	end
endmodule : pwg_gen

// ==== logic/pwg_top.sv ====
// PWM unit top: Avalon-MM registers, clock divider, generators, interrupt
//
// Summary of operation
// - Enable with valid load/compare raises load interrupt
// - Sync bits reload the selected generator counters
// - Counters run on divided system clock
// - Sync is uncertain when divider is nonzero
// - Status clear lands on next PWM tick
// - Clear before first tick after set ignored
`timescale 1ns/1ns
module pwg_top import pwg_pkg::*; (
	input wire logic i_mclk,
	input wire logic i_reset,
	input wire logic i_ce,
	input wire logic [PWG_AW-1:0] i_address,
	input wire logic i_read,
	input wire logic i_write,
	input wire logic [PWG_DW-1:0] i_writedata,
	output logic [PWG_DW-1:0] o_readdata,
	output logic o_waitrequest,
	output logic o_irq
);
	// Bus handshake states
	typedef enum logic {PWG_IDLE, PWG_ANSWER} pwg_bus_t;
	pwg_bus_t bus_st; // Current handshake state
	pwg_bus_t next_bus_st; // Next handshake state

	// Address match for a generator window, used by write and read decode
	function automatic logic gen_hit(input logic [PWG_AW-1:0] a, input int g,
		input logic [7:0] ofs);
		logic [7:0] base;
		base = PWG_GEN_BASE + 8'(g) * PWG_GEN_STRIDE;
		gen_hit = (a == base + ofs);
	endfunction : gen_hit

	// Software state
	logic [PWG_DIVW-1:0] div; // Divider exponent, step every 2**div clocks
	logic [PWG_NGEN-1:0] irq_stat; // Sticky per-generator interrupt events
	logic [PWG_NGEN-1:0] irq_mask; // Enables onto o_irq
	logic [PWG_CTLW-1:0] ctl [PWG_NGEN]; // Generator control
	logic [PWG_CW-1:0] load [PWG_NGEN]; // Generator period
	logic [PWG_CW-1:0] cmpa [PWG_NGEN]; // Compare A
	logic [PWG_CW-1:0] cmpb [PWG_NGEN]; // Compare B
	logic [PWG_PSW-1:0] presc; // Prescaler for the PWM tick
	logic [PWG_NGEN-1:0] gen_irq_q; // Generator irq last cycle

	// Generator outputs
	logic [PWG_CW-1:0] gcount [PWG_NGEN];
	logic [PWG_NISC-1:0] gisc [PWG_NGEN];
	logic [PWG_NGEN-1:0] gen_irq;

	// The transfer completes on the edge where waitrequest is sampled low
	wire req = i_read | i_write;
	wire act = req & (bus_st == PWG_ANSWER);
	wire wr_act = act & i_write;
	wire rd_act = act & i_read;

	// Global decode
	wire hit_clk = (i_address == PWG_OFS_CLKCFG);
	wire hit_sync = (i_address == PWG_OFS_SYNC);
	wire hit_stat = (i_address == PWG_OFS_IRQSTAT);
	wire hit_mask = (i_address == PWG_OFS_IRQMASK);

	// Divided clock: one tick every 2**div system clocks
	// At-or-above compare: a smaller divider written mid-count ticks at once, no long wrap
	wire [PWG_PSW-1:0] presc_top = PWG_PSW'((1 << div) - 1);
	wire div_zero = (div == PWG_RST_DIV);
	wire tick = div_zero | (presc >= presc_top);
	wire [PWG_PSW-1:0] next_presc = tick ? '0 : presc + 7'h01;

	// Sync strobe, one cycle, per generator
	wire [PWG_NGEN-1:0] sync_wr = (wr_act & hit_sync) ? i_writedata[PWG_NGEN-1:0] : '0;

	// Interrupt status: set wins over the read that clears it
	wire [PWG_NGEN-1:0] gen_rise = gen_irq & ~gen_irq_q;
	// Only bits the read returned are cleared, so an event caught at capture time survives
	wire [PWG_NGEN-1:0] stat_keep = (rd_act & hit_stat) ?
		(irq_stat & ~o_readdata[PWG_NGEN-1:0]) : irq_stat;
	wire [PWG_NGEN-1:0] next_stat = stat_keep | gen_rise;

	// Per-generator decode and read paths
	logic [PWG_NGEN-1:0] g_wr_ctl, g_wr_load, g_wr_cmpa, g_wr_cmpb, g_wr_isc;
	logic [PWG_DW-1:0] g_rd [PWG_NGEN];
	logic [PWG_NGEN-1:0] g_hit_any;

	genvar g;
	generate
		for (g = 0; g < PWG_NGEN; g++) begin : gen_units
			wire h_ctl = gen_hit(i_address, g, PWG_GOFS_CTL);
			wire h_load = gen_hit(i_address, g, PWG_GOFS_LOAD);
			wire h_cmpa = gen_hit(i_address, g, PWG_GOFS_CMPA);
			wire h_cmpb = gen_hit(i_address, g, PWG_GOFS_CMPB);
			wire h_cnt = gen_hit(i_address, g, PWG_GOFS_COUNT);
			wire h_isc = gen_hit(i_address, g, PWG_GOFS_ISC);
			assign g_wr_ctl[g] = wr_act & h_ctl;
			assign g_wr_load[g] = wr_act & h_load;
			assign g_wr_cmpa[g] = wr_act & h_cmpa;
			assign g_wr_cmpb[g] = wr_act & h_cmpb;
			assign g_wr_isc[g] = wr_act & h_isc;
			assign g_hit_any[g] = h_ctl | h_load | h_cmpa | h_cmpb | h_cnt | h_isc;
			// Read select, narrower fields zero-extended
			assign g_rd[g] = h_ctl ? PWG_DW'(ctl[g]) :
				h_load ? PWG_DW'(load[g]) :
				h_cmpa ? PWG_DW'(cmpa[g]) :
				h_cmpb ? PWG_DW'(cmpb[g]) :
				h_cnt ? PWG_DW'(gcount[g]) :
				h_isc ? PWG_DW'(gisc[g]) : PWG_RST_WORD;

			// Generator configuration, written by software
			always_ff @(posedge i_mclk) begin
				if (i_reset) begin
					ctl[g] <= '0;
					load[g] <= PWG_RST_CNT;
					cmpa[g] <= PWG_RST_CNT;
					cmpb[g] <= PWG_RST_CNT;
				end else if (i_ce) begin
					if (g_wr_ctl[g]) ctl[g] <= i_writedata[PWG_CTLW-1:0];
					if (g_wr_load[g]) load[g] <= i_writedata[PWG_CW-1:0];
					if (g_wr_cmpa[g]) cmpa[g] <= i_writedata[PWG_CW-1:0];
					if (g_wr_cmpb[g]) cmpb[g] <= i_writedata[PWG_CW-1:0];
				end
			end

			pwg_gen u_gen (
				.i_mclk(i_mclk),
				.i_reset(i_reset),
				.i_ce(i_ce),
				.i_tick(tick),
				.i_div_zero(div_zero),
				.i_sync(sync_wr[g]),
				.i_ctl(ctl[g]),
				.i_load(load[g]),
				.i_cmpa(cmpa[g]),
				.i_cmpb(cmpb[g]),
				.i_isc_wr(g_wr_isc[g]),
				.i_isc_data(i_writedata[PWG_NISC-1:0]),
				.o_count(gcount[g]),
				.o_isc(gisc[g]),
				.o_irq(gen_irq[g])
			);
		end
	endgenerate

	// Read data mux; unmapped addresses read zero
	logic [PWG_DW-1:0] rd_mux;
	always_comb begin
		rd_mux = PWG_RST_WORD;
		if (hit_clk) rd_mux = PWG_DW'(div);
		else if (hit_stat) rd_mux = PWG_DW'(irq_stat);
		else if (hit_mask) rd_mux = PWG_DW'(irq_mask);
		for (int k = 0; k < PWG_NGEN; k++) begin
			if (g_hit_any[k]) rd_mux = g_rd[k];
		end
	end

	// Handshake: one wait cycle, then answer for one cycle
	always_comb begin
		case (bus_st)
			PWG_IDLE: next_bus_st = req ? PWG_ANSWER : PWG_IDLE;
			PWG_ANSWER: next_bus_st = PWG_IDLE;
			default: next_bus_st = PWG_IDLE;
		endcase
	end

	// Bus outputs; read data captured as the answer is posted
	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			bus_st <= PWG_IDLE;
			o_waitrequest <= 1'b1;
			o_readdata <= PWG_RST_WORD;
		end else if (i_ce) begin
			bus_st <= next_bus_st;
			o_waitrequest <= (next_bus_st != PWG_ANSWER);
			if (next_bus_st == PWG_ANSWER) o_readdata <= rd_mux;
		end
	end

	// Global registers, prescaler and interrupt output
	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			div <= PWG_RST_DIV;
			presc <= '0;
			irq_stat <= '0;
			irq_mask <= '0;
			gen_irq_q <= '0;
			o_irq <= 1'b0;
		end else if (i_ce) begin
			if (wr_act & hit_clk) div <= i_writedata[PWG_DIV_LSB +: PWG_DIVW];
			if (wr_act & hit_mask) irq_mask <= i_writedata[PWG_NGEN-1:0];
			presc <= next_presc;
			irq_stat <= next_stat;
			gen_irq_q <= gen_irq;
			o_irq <= |(next_stat & irq_mask);
		end
	end
endmodule : pwg_top

// ==== verification/pwg_monitor.sv ====
// Bus timing and interrupt checks for the PWM unit
`timescale 1ns/1ns
module pwg_monitor import pwg_pkg::*; (
	input wire logic i_mclk,
	input wire logic i_reset,
	input wire logic i_ce,
	input wire logic [PWG_AW-1:0] i_address,
	input wire logic i_read,
	input wire logic i_write,
	input wire logic [PWG_DW-1:0] i_writedata,
	input wire logic [PWG_DW-1:0] o_readdata,
	input wire logic o_waitrequest,
	input wire logic o_irq
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_reset);
	wire logic wr_take = i_ce && i_write && !o_waitrequest; // Write lands here
	wire logic rd_take = i_ce && i_read && !o_waitrequest; // Read data taken here
	logic [PWG_CW-1:0] load0; // Shadow of generator 0 load
	logic [PWG_CW-1:0] cmpa0; // Shadow of generator 0 compare A
	logic en0; // Shadow of generator 0 enable
	logic mask0; // Shadow of mask bit 0
	// Shadows track only what the bus wrote, so the checker needs no internals
	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			{load0, cmpa0, en0, mask0} <= '0;
		end else if (wr_take) begin
			if (i_address == PWG_GEN_BASE + PWG_GOFS_LOAD) load0 <= i_writedata[PWG_CW-1:0];
			if (i_address == PWG_GEN_BASE + PWG_GOFS_CMPA) cmpa0 <= i_writedata[PWG_CW-1:0];
			if (i_address == PWG_GEN_BASE) en0 <= i_writedata[PWG_CTL_EN];
			if (i_address == PWG_OFS_IRQMASK) mask0 <= i_writedata[0];
		end
	end
	// Enable edge with a live load and a compare under it
	wire logic spur = wr_take && i_address == PWG_GEN_BASE && i_writedata[PWG_CTL_EN]
		&& i_writedata[PWG_CTL_LDIE] && !en0 && mask0 && load0 != '0 && cmpa0 < load0;
	answer_next_a: assert property ((i_ce && (i_read || i_write) && o_waitrequest) |=> !o_waitrequest)
		else $error("no answer one cycle after request");
	wait_pulse_a: assert property ((i_ce && !o_waitrequest) |=> o_waitrequest)
		else $error("wait low longer than one cycle");
	reset_quiet_a: assert property ($fell(i_reset) |-> o_waitrequest && !o_irq)
		else $error("bus or irq active out of reset");
	sync_reads_zero_a: assert property (rd_take && i_address == PWG_OFS_SYNC |-> o_readdata == '0)
		else $error("sync register read nonzero");
	div_width_a: assert property (rd_take && i_address == PWG_OFS_CLKCFG
		|-> o_readdata[PWG_DW-1:PWG_DIVW] == '0)
		else $error("divider upper bits set");
	isc_width_a: assert property (rd_take && i_address == PWG_GEN_BASE + PWG_GOFS_ISC
		|-> o_readdata[PWG_DW-1:PWG_NISC] == '0)
		else $error("status upper bits set");
	mask_off_a: assert property (wr_take && i_address == PWG_OFS_IRQMASK
		&& i_writedata[PWG_NGEN-1:0] == '0 |=> ##1 !o_irq [*3])
		else $error("irq high with mask cleared");
	spur_irq_a: assert property (spur |-> ##[1:6] o_irq)
		else $error("no load irq on enable");
	cover property (spur);
	cover property ($rose(o_irq));
	cover property (rd_take && i_address == PWG_GEN_BASE + PWG_GOFS_ISC && o_readdata[0]);
endmodule : pwg_monitor
bind pwg_top pwg_monitor u_mon (.i_mclk(i_mclk), .i_reset(i_reset), .i_ce(i_ce),
	.i_address(i_address), .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata),
	.o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .o_irq(o_irq));

// ==== verification/tb_top.sv ====
// Register-level testbench for the PWM unit
`timescale 1ns/1ns
module tb_top import pwg_pkg::*; ;
	localparam logic [7:0] G0 = PWG_GEN_BASE; // Generator 0 window
	localparam logic [7:0] G1 = PWG_GEN_BASE + PWG_GEN_STRIDE; // Generator 1 window
	logic i_mclk = 1'b0;
	logic i_reset = 1'b1;
	logic i_ce = 1'b1;
	logic [PWG_AW-1:0] i_address = '0;
	logic i_read = 1'b0;
	logic i_write = 1'b0;
	logic [PWG_DW-1:0] i_writedata = '0;
	logic [PWG_DW-1:0] o_readdata;
	logic o_waitrequest;
	logic o_irq;
	int err_count = 0;
	int total_checks = 0;
	logic [PWG_DW-1:0] q; // Scratch read data
	logic [PWG_DW-1:0] c0; // First count sample
	int n;
	always #5 i_mclk = ~i_mclk;
	pwg_top DUT (.i_mclk(i_mclk), .i_reset(i_reset), .i_ce(i_ce), .i_address(i_address),
		.i_read(i_read), .i_write(i_write), .i_writedata(i_writedata),
		.o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .o_irq(o_irq));
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : tally_and_finish
	task automatic chk(input logic [PWG_DW-1:0] got, input logic [PWG_DW-1:0] exp, input string m);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %0t %s got %h want %h", $time, m, got, exp);
		end
	endtask : chk
	// One access; the strobe stays up so a following call runs back to back
	task automatic acc(input logic w, input logic [7:0] a, input logic [PWG_DW-1:0] d,
		output logic [PWG_DW-1:0] r);
		int k;
		k = 0;
		i_write <= w;
		i_read <= !w;
		i_address <= a;
		i_writedata <= d;
		// Read before this edge's updates land, so these are the values the slave presents
		do begin
			@(posedge i_mclk);
			k++;
		end while (o_waitrequest !== 1'b0 && k < 50);
		if (k >= 50) begin
			chk(1, 0, "bus hang");
			tally_and_finish();
		end
		r = o_readdata;
	endtask : acc
	task automatic wr(input logic [7:0] a, input logic [PWG_DW-1:0] d);
		logic [PWG_DW-1:0] x;
		acc(1'b1, a, d, x);
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [PWG_DW-1:0] d);
		acc(1'b0, a, '0, d);
	endtask : rd
	task automatic idle(input int k);
		i_read <= 1'b0;
		i_write <= 1'b0;
		repeat (k) @(posedge i_mclk);
	endtask : idle
	// Poll generator 1 count until it steps, so a PWM tick has just passed
	task automatic wait_tick;
		logic [PWG_DW-1:0] a;
		logic [PWG_DW-1:0] b;
		int k;
		k = 0;
		rd(G1 + PWG_GOFS_COUNT, a);
		do begin
			rd(G1 + PWG_GOFS_COUNT, b);
			k++;
		end while (b === a && k < 200);
		if (k >= 200) begin
			chk(1, 0, "no tick");
			tally_and_finish();
		end
	endtask : wait_tick
	initial begin
		repeat (20) @(posedge i_mclk);
		i_reset <= 1'b0;
		@(posedge i_mclk);
		wr(8'hFC, 32'hFFFFFFFF);
		for (int k = 0; k < 6; k++) begin
			rd(8'(PWG_OFS_CLKCFG + 4 * k), c0);
			chk(c0, '0, "reset or hole");
		end
		rd(8'hFC, q);
		chk(q, '0, "unmapped");
		$display("test reset done");
		wr(G0 + PWG_GOFS_LOAD, 32'h0000F000);
		wr(G0 + PWG_GOFS_CTL, 32'h00000001);
		for (int d = 0; d < 4; d++) begin
			wr(PWG_OFS_CLKCFG, 32'(d));
			idle(12);
			rd(G0 + PWG_GOFS_COUNT, c0);
			repeat (4) rd(G0 + PWG_GOFS_COUNT, q);
			chk(c0 - q, 32'(8 >> d), "count rate");
		end
		$display("test divider done");
		wr(PWG_OFS_CLKCFG, 32'h0);
		wr(G1 + PWG_GOFS_LOAD, 32'h0000F000);
		wr(G1 + PWG_GOFS_CTL, 32'h00000001);
		wr(PWG_OFS_SYNC, 32'h00000003);
		rd(G0 + PWG_GOFS_COUNT, c0);
		rd(G1 + PWG_GOFS_COUNT, q);
		chk(c0 - q, 32'h2, "sync");
		// Clock enable low for ten edges must freeze the counter
		rd(G0 + PWG_GOFS_COUNT, c0);
		i_ce <= 1'b0;
		idle(10);
		i_ce <= 1'b1;
		rd(G0 + PWG_GOFS_COUNT, q);
		chk(c0 - q, 32'h2, "clock enable hold");
		$display("test sync done");
		wr(PWG_OFS_CLKCFG, 32'h7);
		wr(PWG_OFS_IRQMASK, 32'h1);
		wr(G0 + PWG_GOFS_CTL, 32'h0);
		wr(G0 + PWG_GOFS_LOAD, 32'h100);
		wr(G0 + PWG_GOFS_CMPA, 32'h10);
		wr(G0 + PWG_GOFS_CMPB, 32'hFFFF);
		rd(PWG_OFS_IRQSTAT, q);
		wait_tick();
		wr(G0 + PWG_GOFS_CTL, 32'h3);
		idle(1);
		n = 0;
		while (o_irq !== 1'b1 && n < 10) begin
			@(negedge i_mclk);
			n++;
		end
		@(posedge i_mclk);
		chk({31'h0, o_irq}, 32'h1, "enable irq");
		wr(G0 + PWG_GOFS_ISC, 32'h1);
		wait_tick();
		wait_tick();
		rd(G0 + PWG_GOFS_ISC, q);
		chk(q, 32'h1, "early clear kept");
		rd(PWG_OFS_IRQSTAT, q);
		chk(q, 32'h1, "irq status");
		idle(3);
		chk({31'h0, o_irq}, 32'h0, "irq after read");
		wait_tick();
		wr(G0 + PWG_GOFS_ISC, 32'h1);
		rd(G0 + PWG_GOFS_ISC, q);
		chk(q, 32'h1, "clear before tick");
		wait_tick();
		rd(G0 + PWG_GOFS_ISC, q);
		chk(q, 32'h0, "clear at tick");
		// Sync written well away from a tick with the divider set is lost
		rd(G1 + PWG_GOFS_COUNT, c0);
		wr(PWG_OFS_SYNC, 32'h00000002);
		rd(G1 + PWG_GOFS_COUNT, q);
		chk(q, c0, "sync off tick");
		wr(PWG_OFS_IRQMASK, 32'h0);
		idle(4);
		$display("test interrupt done");
		tally_and_finish();
	end
endmodule : tb_top
